//--- hw/edo_dram_cycle_timing.sv
// controller that drives the extended output page memory strobes
// How it works
// - random cycle starts spaced at least the row cycle time apart.
// - row strobe low at least its minimum and below its long limit.
// - column strobe falls inside the row-to-column delay window.
// - column address driven inside the row-to-address delay window.
// - page column cycles no faster than the page cycle time.
// - page read-write column cycles spaced at least 56 ns.
// - read-modify-write enable falls late enough after row fall.
// - read-modify-write enable falls late enough after column fall.
// - read-modify-write enable falls late enough after address valid.
// - all 1024 rows refreshed every 16 ms.
// - refresh column strobe leads row fall and holds after.
// - column strobe high before each access row fall.
// - output enable asserted at row fall for reads and read-modify-writes.
// - write enable held long enough after row fall in writes.
// - wait 200 us then eight refresh cycles; repeat when overdue.
`timescale 1ns/1ps
`default_nettype none
`include "edo_ctrl_regs.svh"
module edo_dram_cycle_timing
  import edo_ctrl_pkg::*;
#(
  parameter bit FAST_GRADE = 1'b1,
  parameter int PWRUP_CYCLES = (`T_PWRUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int REF_INTERVAL_CYCLES =
    (`T_REF_MS * 1000000 / `REF_ROWS) / `CLK_PERIOD_NS,
  parameter int PAGE_MAX_CYCLES = 100000 / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // user request
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic [9:0] req_row_in,
  input wire logic [9:0] req_col_in,
  input wire logic [1:0] req_byte_en_in,
  input wire logic [15:0] req_wdata_in,
  input wire logic req_page_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [15:0] rd_data_out,
  output logic init_done_out,
  // memory pins
  output logic row_strobe_n_out,
  output logic lower_byte_column_strobe_n_out,
  output logic upper_byte_column_strobe_n_out,
  output logic write_enable_n_out,
  output logic output_enable_n_out,
  output logic [9:0] addr_out,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe_out
);
  // cycle counts from ns limits, chosen by grade
  function automatic int up(input int ns);
    return (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  endfunction : up
  function automatic int dn(input int ns);
    return (ns / `CLK_PERIOD_NS < 1) ? 1 : ns / `CLK_PERIOD_NS;
  endfunction : dn
  function automatic int g(input int f, input int s);
    return FAST_GRADE ? f : s;
  endfunction : g
  localparam int C_RCD = up(g(`T_RCD_NS_F, `T_RCD_NS_S));
  localparam int C_RCD_MAX = dn(g(`T_RCD_MAX_NS_F, `T_RCD_MAX_NS_S));
  localparam int C_ROWCOL = (C_RCD > C_RCD_MAX) ? C_RCD_MAX : C_RCD;
  localparam int C_ACC = up(g(`T_AA_NS_F, `T_AA_NS_S) > g(`T_CAC_NS_F, `T_CAC_NS_S) ?
    g(`T_AA_NS_F, `T_AA_NS_S) : g(`T_CAC_NS_F, `T_CAC_NS_S)) + 2;
  localparam int C_PC = up(g(`T_PC_NS_F, `T_PC_NS_S));
  localparam int C_PRWC = up(`T_PRWC_NS);
  localparam int C_CWD = up(g(`T_CWD_NS_F, `T_CWD_NS_S));
  localparam int C_RWD = up(g(`T_RWD_NS_F, `T_RWD_NS_S));
  localparam int C_AWD = up(g(`T_AWD_NS_F, `T_AWD_NS_S));
  localparam int C_WCR = up(g(`T_WCR_NS_F, `T_WCR_NS_S));
  localparam int C_RAS = up(g(`T_RAS_NS_F, `T_RAS_NS_S));
  localparam int C_RAS_MAX = dn(`T_RAS_MAX_NS);
  localparam int C_RP = up(g(`T_RP_NS_F, `T_RP_NS_S));
  localparam int C_RC = up(g(`T_RC_NS_F, `T_RC_NS_S));
  localparam int C_CSR = up(`T_CSR_NS);
  localparam int C_CHR = up(g(`T_CHR_NS_F, `T_CHR_NS_S));
  localparam int C_RPC = up(`T_RPC_NS);
  localparam int C_OFF = up(g(`T_OFF_MAX_NS_F, `T_OFF_MAX_NS_S));
  localparam int C_WPZ = up(`T_WPZ_NS);

  ctrl_state_t state;
  op_t op;
  logic [15:0] since_ras;
  logic ref_end;
  logic [31:0] ref_timer;
  logic ref_due;
  logic ref_overdue;
  logic [3:0] init_left;
  logic page;
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  logic [15:0] wdata;
  logic [9:0] col;
  logic [1:0] byte_en;
  logic take;
  logic [15:0] last_wait;

  cycle_timer_if tif ();
  cycle_timer u_timer (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .t(tif)
  );

  // two flops on the data pins; sampling occurs after the access window plus sync delay
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  assign take = (state == ST_IDLE) && req_valid_in && !ref_due && tif.done && init_done_out;
  assign req_ready_out = take;

  function automatic logic [15:0] w(input int v);
    return v[15:0];
  endfunction : w
  function automatic logic [15:0] mx(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction : mx
  // remaining wait, never wrapping once the interval has already passed
  function automatic logic [15:0] rest(input int need, input logic [15:0] have);
    return (need > int'(have)) ? w(need - int'(have)) : 16'h0001;
  endfunction : rest

  assign ref_end = (state == ST_REF_RAS) && (since_ras >= w(C_RAS));

  // refresh pacing; overdue forces a fresh eight-cycle wake-up
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ref_timer <= 32'h00000000;
      ref_due <= 1'b0;
      ref_overdue <= 1'b0;
    end else begin
      if (ref_end) begin
        ref_due <= 1'b0;
        ref_timer <= 32'h00000000;
      end else if (init_done_out) begin
        ref_timer <= ref_timer + 32'h00000001;
        if (ref_timer >= REF_INTERVAL_CYCLES[31:0]) begin
          ref_due <= 1'b1;
        end
        if (ref_timer >= 32'(REF_INTERVAL_CYCLES * 2)) begin
          ref_overdue <= 1'b1;
        end
      end
      if (ref_overdue && init_left != 4'h0) begin
        ref_overdue <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      init_left <= 4'(`INIT_CYCLES);
      init_done_out <= 1'b0;
    end else if (ref_overdue && init_done_out) begin
      init_left <= 4'(`INIT_CYCLES);
      init_done_out <= 1'b0;
    end else if (ref_end && init_left != 4'h0) begin
      init_left <= init_left - 4'h1;
      if (init_left == 4'h1) begin
        init_done_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || state == ST_IDLE || state == ST_REF_CAS) begin
      since_ras <= 16'h0000;
    end else if (since_ras != 16'hffff) begin
      since_ras <= since_ras + 16'h0001;
    end
  end

  // main sequencer: timer loads at each transition except those into ST_IDLE
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state <= ST_PWRUP;
      op <= OP_READ;
      page <= 1'b0;
      col <= 10'h000;
      byte_en <= 2'h0;
      wdata <= 16'h0000;
      last_wait <= 16'h0000;
      row_strobe_n_out <= 1'b1;
      lower_byte_column_strobe_n_out <= 1'b1;
      upper_byte_column_strobe_n_out <= 1'b1;
      write_enable_n_out <= 1'b1;
      output_enable_n_out <= 1'b1;
      addr_out <= 10'h000;
      dq_out <= 16'h0000;
      dq_oe_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= 16'h0000;
      tif.load <= 1'b1;
      tif.count <= w(PWRUP_CYCLES);
    end else begin
      tif.load <= 1'b0;
      rd_valid_out <= 1'b0;
      case (state)
        ST_PWRUP: begin
          if (tif.done) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (tif.done && (ref_due || !init_done_out)) begin
            lower_byte_column_strobe_n_out <= 1'b0;
            upper_byte_column_strobe_n_out <= 1'b0;
            state <= ST_REF_CAS;
            tif.load <= 1'b1;
            tif.count <= w(C_CSR);
          end else if (take) begin
            op <= op_t'(req_op_in);
            page <= req_page_in;
            col <= req_col_in;
            byte_en <= req_byte_en_in;
            wdata <= req_wdata_in;
            addr_out <= req_row_in;
            row_strobe_n_out <= 1'b0;
            output_enable_n_out <= (req_op_in == OP_WRITE);
            state <= ST_ROW;
            tif.load <= 1'b1;
            tif.count <= w(C_ROWCOL);
          end
        end
        ST_ROW: begin
          if (tif.done) begin
            addr_out <= col;
            lower_byte_column_strobe_n_out <= !byte_en[0];
            upper_byte_column_strobe_n_out <= !byte_en[1];
            if (op == OP_WRITE) begin
              write_enable_n_out <= 1'b0;
              dq_out <= wdata;
              dq_oe_out <= 1'b1;
            end
            state <= ST_COL;
            tif.load <= 1'b1;
            tif.count <= (op == OP_WRITE) ? w(C_WCR) :
              mx(w(C_ACC), rest(C_RAS + 3, since_ras));
          end
        end
        ST_COL: begin
          if (tif.done) begin
            if (op != OP_WRITE) begin
              rd_data_out <= dq_s2;
              rd_valid_out <= 1'b1;
            end
            if (op == OP_RMW) begin
              state <= ST_RMW_WE;
              tif.load <= 1'b1;
              tif.count <= mx(mx(w(C_CWD), w(C_AWD)), rest(C_RWD, since_ras));
            end else begin
              write_enable_n_out <= 1'b1;
              state <= ST_DATA;
              tif.load <= 1'b1;
              tif.count <= w(1);
            end
          end
        end
        ST_RMW_WE: begin
          if (tif.done) begin
            output_enable_n_out <= 1'b1;
            write_enable_n_out <= 1'b0;
            dq_out <= wdata;
            dq_oe_out <= 1'b1;
            state <= ST_DATA;
            tif.load <= 1'b1;
            tif.count <= w(C_WCR);
          end
        end
        ST_DATA: begin
          if (tif.done) begin
            lower_byte_column_strobe_n_out <= 1'b1;
            upper_byte_column_strobe_n_out <= 1'b1;
            write_enable_n_out <= 1'b1;
            dq_oe_out <= 1'b0;
            last_wait <= (op == OP_RMW) ? w(C_PRWC) : w(C_PC);
            if (page && req_valid_in && req_op_in == op && !ref_due &&
                since_ras < w(C_RAS_MAX < PAGE_MAX_CYCLES ? C_RAS_MAX : PAGE_MAX_CYCLES) -
                w(C_PRWC + C_RC)) begin
              col <= req_col_in;
              byte_en <= req_byte_en_in;
              wdata <= req_wdata_in;
              page <= req_page_in;
              state <= ST_PAGE_PRE;
              tif.load <= 1'b1;
              tif.count <= w(1);
            end else begin
              state <= ST_RAS_HOLD;
              tif.load <= 1'b1;
              tif.count <= rest(C_RAS, since_ras);
            end
          end
        end
        ST_PAGE_PRE: begin
          if (tif.done) begin
            addr_out <= col;
            lower_byte_column_strobe_n_out <= !byte_en[0];
            upper_byte_column_strobe_n_out <= !byte_en[1];
            if (op == OP_WRITE) begin
              write_enable_n_out <= 1'b0;
              dq_out <= wdata;
              dq_oe_out <= 1'b1;
            end
            state <= ST_COL;
            tif.load <= 1'b1;
            tif.count <= mx(w(C_ACC), last_wait - 16'h0002);
          end
        end
        ST_RAS_HOLD: begin
          if (tif.done) begin
            row_strobe_n_out <= 1'b1;
            output_enable_n_out <= 1'b1;
            state <= ST_PRECHG;
            tif.load <= 1'b1;
            tif.count <= mx(mx(w(C_RP), w(C_OFF)), rest(C_RC, since_ras));
          end
        end
        ST_PRECHG: begin
          if (tif.done) begin
            state <= ST_IDLE;
          end
        end
        ST_REF_CAS: begin
          if (tif.done) begin
            row_strobe_n_out <= 1'b0;
            state <= ST_REF_RAS;
            tif.load <= 1'b1;
            tif.count <= w(C_CHR);
          end
        end
        ST_REF_RAS: begin
          if (since_ras >= w(C_CHR)) begin
            lower_byte_column_strobe_n_out <= 1'b1;
            upper_byte_column_strobe_n_out <= 1'b1;
          end
          if (since_ras >= w(C_RAS)) begin
            row_strobe_n_out <= 1'b1;
            state <= ST_PRECHG;
            tif.load <= 1'b1;
            tif.count <= mx(w(C_RP), w(C_RPC));
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : edo_dram_cycle_timing
`default_nettype wire

//--- hw/edo_ctrl_regs.svh
// timing constants of the extended output page memory controller
`ifndef EDO_CTRL_REGS_SVH
`define EDO_CTRL_REGS_SVH
`define CLK_PERIOD_NS 20
`define T_RC_NS_F 85
`define T_RC_NS_S 110
`define T_RAS_NS_F 50
`define T_RAS_NS_S 60
`define T_RAS_MAX_NS 10000
`define T_RCD_NS_F 12
`define T_RCD_NS_S 20
`define T_RCD_MAX_NS_F 37
`define T_RCD_MAX_NS_S 45
`define T_RAD_NS_F 14
`define T_RAD_NS_S 15
`define T_AA_NS_F 25
`define T_AA_NS_S 30
`define T_CAC_NS_F 14
`define T_CAC_NS_S 15
`define T_PC_NS_F 30
`define T_PC_NS_S 40
`define T_PRWC_NS 56
`define T_RWD_NS_F 65
`define T_RWD_NS_S 85
`define T_CWD_NS_F 26
`define T_CWD_NS_S 40
`define T_AWD_NS_F 40
`define T_AWD_NS_S 55
`define T_WCR_NS_F 40
`define T_WCR_NS_S 50
`define T_CSR_NS 5
`define T_CHR_NS_F 8
`define T_CHR_NS_S 10
`define T_RPC_NS 5
`define T_RP_NS_F 30
`define T_RP_NS_S 40
`define T_OFF_MAX_NS_F 12
`define T_OFF_MAX_NS_S 15
`define T_WPZ_NS 10
`define T_REF_MS 16
`define REF_ROWS 1024
`define T_PWRUP_US 200
`define INIT_CYCLES 8
`endif

//--- hw/edo_ctrl_pkg.sv
// types shared by the memory controller modules
package edo_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_PWRUP = 4'h0,
    ST_IDLE = 4'h1,
    ST_ROW = 4'h2,
    ST_COL = 4'h3,
    ST_DATA = 4'h4,
    ST_RMW_WE = 4'h5,
    ST_PAGE_PRE = 4'h6,
    ST_RAS_HOLD = 4'h7,
    ST_PRECHG = 4'h8,
    ST_REF_CAS = 4'h9,
    ST_REF_RAS = 4'ha
  } ctrl_state_t;
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_RMW = 2'h2
  } op_t;
endpackage : edo_ctrl_pkg

//--- hw/cycle_timer_if.sv
// load and done signals between controller and its cycle timer
`timescale 1ns/1ps
`default_nettype none
interface cycle_timer_if;
  logic load;
  logic [15:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : cycle_timer_if
`default_nettype wire

//--- hw/cycle_timer.sv
// down counter timing the strobe intervals
`timescale 1ns/1ps
`default_nettype none
module cycle_timer (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // timer port
  cycle_timer_if.tmr t
);
  logic [15:0] remain;
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      remain <= 16'h0000;
    end else if (t.load) begin
      remain <= (t.count > 16'h0002) ? t.count - 16'h0002 : 16'h0000;
    end else if (remain != 16'h0000) begin
      remain <= remain - 16'h0001;
    end
  end
  // done in the load cycle for a one-cycle wait, so a count of n spans n cycles
  assign t.done = t.load ? (t.count <= 16'h0001) : (remain == 16'h0000);
endmodule : cycle_timer
`default_nettype wire

//--- bench/edo_ctrl_monitor.sv
// concurrent checks on the memory pins of the strobe controller
`timescale 1ns/1ps
`default_nettype none
module edo_ctrl_monitor #(
  parameter int REF_INTERVAL_CYCLES = 781
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // user side
  input wire logic req_valid_in,
  input wire logic [9:0] req_col_in,
  input wire logic req_ready_out,
  input wire logic init_done_out,
  // memory pins
  input wire logic row_strobe_n_out,
  input wire logic lower_byte_column_strobe_n_out,
  input wire logic upper_byte_column_strobe_n_out,
  input wire logic write_enable_n_out,
  input wire logic [9:0] addr_out
);
  // a due refresh may wait for the access in flight to finish
  localparam int REF_SLACK = 32;
  logic cas_n;
  logic row_was_high;
  logic ref_fall;
  logic [9:0] taken_col;
  int since_ref;
  int wake_refs;
  assign cas_n = lower_byte_column_strobe_n_out & upper_byte_column_strobe_n_out;
  assign ref_fall = row_was_high && !row_strobe_n_out && !cas_n;
  always_ff @(posedge sys_clk_in) begin
    row_was_high <= row_strobe_n_out;
  end
  always_ff @(posedge sys_clk_in) begin
    if (req_valid_in && req_ready_out) taken_col <= req_col_in;
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || !init_done_out || ref_fall) since_ref <= 0;
    else since_ref <= since_ref + 1;
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) wake_refs <= 0;
    else if (ref_fall) wake_refs <= wake_refs + 1;
  end
  default clocking mon_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  chk_ras_low_width: assert property ($fell(row_strobe_n_out) |-> !row_strobe_n_out [*3])
    else $error("row strobe low too short");
  chk_cycle_spacing: assert property ($fell(row_strobe_n_out) |-> ##1 (!$fell(row_strobe_n_out)) [*4])
    else $error("row cycles too close");
  chk_col_delay: assert property ($fell(row_strobe_n_out) && cas_n |-> ##1 !cas_n)
    else $error("column strobe outside its delay window");
  chk_col_addr: assert property ($fell(row_strobe_n_out) && cas_n |-> ##1 addr_out == taken_col)
    else $error("column address not presented in time");
  chk_refresh_order: assert property ($fell(row_strobe_n_out) && !cas_n |-> !$past(cas_n) ##1 !cas_n)
    else $error("refresh column strobe setup or hold short");
  chk_cas_precharge: assert property ($fell(row_strobe_n_out) && cas_n |-> $past(cas_n))
    else $error("column strobe not high before row fall");
  chk_rmw_row_delay: assert property ($fell(write_enable_n_out) && !cas_n && !$past(cas_n)
    |-> $past(row_strobe_n_out, 4) == 1'b0)
    else $error("late write enable too soon after row fall");
  chk_rmw_col_delay: assert property ($fell(write_enable_n_out) && !cas_n && !$past(cas_n)
    |-> $past(cas_n, 2) == 1'b0)
    else $error("late write enable too soon after column fall");
  chk_we_row_hold: assert property ($rose(write_enable_n_out) |-> $past(row_strobe_n_out, 2) == 1'b0)
    else $error("write enable released too soon after row fall");
  chk_ref_period: assert property (since_ref <= REF_INTERVAL_CYCLES + REF_SLACK)
    else $error("refresh interval exceeded");
  chk_wake_refs: assert property ($rose(init_done_out) |-> wake_refs >= 8)
    else $error("ready before eight wake refreshes");
  chk_no_early_take: assert property (!init_done_out |-> !req_ready_out)
    else $error("request accepted before wake up");
  cover property ($fell(row_strobe_n_out) && cas_n);
  cover property (ref_fall);
  cover property ($fell(write_enable_n_out) && !cas_n && !$past(cas_n));
endmodule : edo_ctrl_monitor
bind edo_dram_cycle_timing edo_ctrl_monitor #(.REF_INTERVAL_CYCLES(REF_INTERVAL_CYCLES)) mon_u (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in),
  .req_col_in(req_col_in), .req_ready_out(req_ready_out), .init_done_out(init_done_out),
  .row_strobe_n_out(row_strobe_n_out),
  .lower_byte_column_strobe_n_out(lower_byte_column_strobe_n_out),
  .upper_byte_column_strobe_n_out(upper_byte_column_strobe_n_out),
  .write_enable_n_out(write_enable_n_out), .addr_out(addr_out));
`default_nettype wire

//--- bench/edo_mem_model.sv
// behavioural model of the extended output page memory
`timescale 1ns/1ps
`default_nettype none
module edo_mem_model #(
  parameter int ACCESS_NS = 25,
  parameter int HOLD_NS = 5,
  parameter int OFF_NS = 12,
  parameter int WE_OFF_NS = 10
) (
  // memory pins
  input wire logic row_strobe_n_in,
  input wire logic lower_byte_column_strobe_n_in,
  input wire logic upper_byte_column_strobe_n_in,
  input wire logic write_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic [9:0] addr_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  // refresh count for the bench
  output var int refresh_count
);
  logic [15:0] mem [logic [19:0]];
  logic [9:0] row;
  logic [19:0] key;
  logic [15:0] word;
  logic cas_n;
  assign cas_n = lower_byte_column_strobe_n_in & upper_byte_column_strobe_n_in;
  initial begin
    dq_out = 16'h0000;
    refresh_count = 0;
    row = 10'h000;
  end
  task automatic store();
    word = mem.exists(key) ? mem[key] : 16'h0000;
    if (!lower_byte_column_strobe_n_in) word[7:0] = dq_in[7:0];
    if (!upper_byte_column_strobe_n_in) word[15:8] = dq_in[15:8];
    mem[key] = word;
  endtask : store
  // refresh ignores the address pins and never drives data
  // pins launched on the same edge as a strobe are read a step later
  always @(negedge row_strobe_n_in) begin
    #1;
    if (!cas_n) refresh_count++;
    else row = addr_in;
  end
  always @(negedge cas_n) begin
    #1;
    key = {row, addr_in};
    if (!row_strobe_n_in && !write_enable_n_in) store();
    else if (!row_strobe_n_in && !output_enable_n_in) begin
      word = mem.exists(key) ? mem[key] : 16'h0000;
      dq_out <= #(HOLD_NS) ~dq_out;
      dq_out <= #(ACCESS_NS) word;
    end
  end
  always @(negedge write_enable_n_in) begin
    #2;
    if (!row_strobe_n_in && !cas_n) begin
      store();
      dq_out <= #(WE_OFF_NS) ~dq_out;
    end
  end
  // undriven lines show no stale value, hence the inversion
  always @(posedge row_strobe_n_in or posedge cas_n) begin
    if (row_strobe_n_in && cas_n) dq_out <= #(OFF_NS) ~dq_out;
  end
endmodule : edo_mem_model
`default_nettype wire

//--- bench/edo_dram_cycle_timing_tb.sv
// self-checking bench for the strobe controller
`timescale 1ns/1ps
`default_nettype none
module edo_dram_cycle_timing_tb
  import edo_ctrl_pkg::*;
;
  localparam int REF_CYC = 200;
  typedef struct {
    op_t op;
    logic [9:0] row;
    logic [9:0] col;
    logic [1:0] be;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } case_t;
  case_t cases [8] = '{
    '{OP_WRITE, 10'h005, 10'h003, 2'h3, 16'h1234, 16'h0000},
    '{OP_READ, 10'h005, 10'h003, 2'h3, 16'h0000, 16'h1234},
    '{OP_WRITE, 10'h005, 10'h003, 2'h1, 16'hffee, 16'h0000},
    '{OP_READ, 10'h005, 10'h003, 2'h3, 16'h0000, 16'h12ee},
    '{OP_WRITE, 10'h005, 10'h004, 2'h2, 16'h7788, 16'h0000},
    '{OP_READ, 10'h005, 10'h004, 2'h3, 16'h0000, 16'h7700},
    '{OP_RMW, 10'h3ff, 10'h3ff, 2'h3, 16'habcd, 16'h0000},
    '{OP_READ, 10'h3ff, 10'h3ff, 2'h3, 16'h0000, 16'habcd}};
  logic sys_clk_in, rstn_in, req_valid_in, req_ready_out, rd_valid_out, init_done_out;
  logic req_page_in;
  logic [1:0] req_op_in, req_byte_en_in;
  logic [9:0] req_row_in, req_col_in, addr_out;
  logic [15:0] req_wdata_in, rd_data_out, dq_ctrl, dq_mem, dq_bus, got;
  logic row_n, lower_byte_column_strobe_n_n, upper_byte_column_strobe_n_n, we_n, oe_n, dq_oe_out;
  int refresh_count, base, n_errors, cmp_count;
  assign dq_bus = dq_oe_out ? dq_ctrl : dq_mem;
  edo_dram_cycle_timing #(.PWRUP_CYCLES(20), .REF_INTERVAL_CYCLES(REF_CYC)) dut_u (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_row_in(req_row_in), .req_col_in(req_col_in),
    .req_byte_en_in(req_byte_en_in), .req_wdata_in(req_wdata_in), .req_page_in(req_page_in),
    .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .init_done_out(init_done_out), .row_strobe_n_out(row_n),
    .lower_byte_column_strobe_n_out(lower_byte_column_strobe_n_n), .upper_byte_column_strobe_n_out(upper_byte_column_strobe_n_n),
    .write_enable_n_out(we_n), .output_enable_n_out(oe_n), .addr_out(addr_out),
    .dq_in(dq_bus), .dq_out(dq_ctrl), .dq_oe_out(dq_oe_out));
  edo_mem_model mem_u (
    .row_strobe_n_in(row_n), .lower_byte_column_strobe_n_in(lower_byte_column_strobe_n_n),
    .upper_byte_column_strobe_n_in(upper_byte_column_strobe_n_n), .write_enable_n_in(we_n),
    .output_enable_n_in(oe_n), .addr_in(addr_out), .dq_in(dq_bus), .dq_out(dq_mem),
    .refresh_count(refresh_count));
  always #10 sys_clk_in = ~sys_clk_in;
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk_bit
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // a refused request is held until ready is seen or the bound ends the wait
  task automatic send(input case_t c, output logic ok);
    int n;
    @(posedge sys_clk_in);
    req_op_in <= c.op;
    req_row_in <= c.row;
    req_col_in <= c.col;
    req_byte_en_in <= c.be;
    req_wdata_in <= c.wdata;
    req_valid_in <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 2000);
    req_valid_in <= 1'b0;
    ok = (n < 2000);
  endtask : send
  task automatic get_read(output logic [15:0] d);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (rd_valid_out !== 1'b1 && n < 100);
    d = (n < 100) ? rd_data_out : 16'hxxxx;
  endtask : get_read
  task automatic wait_init(output logic ok);
    int n;
    n = 0;
    while (init_done_out !== 1'b1 && n < 5000) begin
      @(posedge sys_clk_in);
      n++;
    end
    ok = (n < 5000);
  endtask : wait_init
  initial begin
    #400000;
    n_errors++;
    $display("watchdog expired");
    give_verdict();
  end
  initial begin
    logic ok;
    sys_clk_in = 1'b0;
    rstn_in = 1'b0;
    req_valid_in = 1'b0;
    req_page_in = 1'b0;
    req_op_in = 2'h0;
    req_row_in = 10'h000;
    req_col_in = 10'h000;
    req_byte_en_in = 2'h0;
    req_wdata_in = 16'h0000;
    n_errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge sys_clk_in);
    chk_bit("ready in reset", 1'b0, req_ready_out);
    chk_bit("row strobe in reset", 1'b1, row_n);
    rstn_in <= 1'b1;
    wait_init(ok);
    chk_bit("init done", 1'b1, ok);
    chk_bit("wake refreshes", 1'b1, refresh_count >= 8);
    $display("test reset done");
    foreach (cases[i]) begin
      send(cases[i], ok);
      chk_bit("request taken", 1'b1, ok);
      if (cases[i].op != OP_WRITE) begin
        get_read(got);
        chk_word("read data", cases[i].rdata, got);
      end
    end
    $display("test table done");
    // page continuation is taken without a ready pulse, so it is held until its data
    req_page_in <= 1'b1;
    send(cases[3], ok);
    @(posedge sys_clk_in);
    req_col_in <= cases[5].col;
    req_page_in <= 1'b0;
    req_valid_in <= 1'b1;
    get_read(got);
    chk_word("page first", cases[3].rdata, got);
    get_read(got);
    req_valid_in <= 1'b0;
    chk_word("page second", cases[5].rdata, got);
    $display("test page done");
    base = refresh_count;
    repeat (3 * REF_CYC) @(posedge sys_clk_in);
    chk_bit("idle refreshes", 1'b1, refresh_count - base >= 2);
    $display("test refresh done");
    rstn_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk_bit("init after reset", 1'b0, init_done_out);
    base = refresh_count;
    rstn_in <= 1'b1;
    wait_init(ok);
    chk_bit("wake after reset", 1'b1, ok && refresh_count - base >= 8);
    send(cases[3], ok);
    get_read(got);
    chk_word("data kept", cases[3].rdata, got);
    $display("test second reset done");
    give_verdict();
  end
endmodule : edo_dram_cycle_timing_tb
`default_nettype wire
